// File: src/ccpu_unit.sv
// PWM unit: period timer with prescaler, double-buffered duty, output
// pin with pin mapping, internal taps, and a classic Wishbone slave.
// Assumes one system clock and a synchronous active-high reset.
//
// Functional notes
// - A pulse width longer than the period leaves the output at its level.
// - All PWM timing is counted straight from the system clock.
// - Reset restores every register and turns the pins to input.
// - The waveform feeds wave generator, ADC, timer reset, window, logic cell.
// - The pin output is steered to a selectable physical pin.
// - Control bit 5 reads the output level and ignores writes.
// - After timer equals limit, clear timer, set pin unless zero or over period, latch duty.
// - The alignment bit selects how the duty pair packs the 10-bit value.
// - Timer plus two sub bits form a time base whose duty match clears pin.
// - Duty writes at any time only take hold at the next period.
`timescale 1ns/100ps
`default_nettype none

module ccpu_unit
  import ccpu_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mapped pins
  output logic [PIN_COUNT-1:0] pin_o,
  output logic [PIN_COUNT-1:0] pin_oe_o,
  // Internal consumers
  output ccpu_taps_s taps_o
);

  // Mask of prescaler bits for one timer step
  function automatic logic [7:0] ps_mask(input logic [1:0] sel);
    case (sel)
      2'h0: ps_mask = PS_MASK_1;
      2'h1: ps_mask = PS_MASK_4;
      2'h2: ps_mask = PS_MASK_16;
      default: ps_mask = PS_MASK_64;
    endcase
  endfunction

  // Two low time-base bits: clock phase or top prescaler bits
  function automatic logic [1:0] sub_bits(input logic [7:0] ps,
                                          input logic [1:0] sel);
    case (sel)
      2'h0: sub_bits = ps[1:0];
      2'h1: sub_bits = ps[3:2];
      2'h2: sub_bits = ps[5:4];
      default: sub_bits = ps[7:6];
    endcase
  endfunction

  // Pack the duty pair by alignment
  function automatic logic [9:0] duty_of(input logic fmt,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
    duty_of = fmt ? {hi, lo[7:6]} : {hi[1:0], lo};
  endfunction

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] dlo_q, dlo_d, dhi_q, dhi_d;
  logic [7:0] pr_q, pr_d, tctl_q, tctl_d, pctl_q, pctl_d;
  logic [7:0] ps_q, ps_d, tmr_q, tmr_d;
  logic [9:0] dbuf_q, dbuf_d;
  logic out_q, out_d;
  logic [PIN_COUNT-1:0] pin_d, oe_d;
  logic [31:0] rdat_d;
  logic ack_d;
  logic pwm_on, tick_end, roll, over;
  logic [9:0] duty_val, tb_next;
  logic [10:0] period_len;
  logic [7:0] ctrl_rd;
  logic wr;

  // Mode decode and time base
  always_comb
  begin
    pwm_on = ctrl_q[CTL_EN] & ctrl_q[CTL_MODE_HI]
             & ctrl_q[CTL_MODE_LO];
    tick_end = tctl_q[TCT_ON]
               & ((ps_q & ps_mask(tctl_q[TCT_PS_HI:0]))
                  == ps_mask(tctl_q[TCT_PS_HI:0]));
    roll = tick_end & (tmr_q == pr_q);
    duty_val = duty_of(ctrl_q[CTL_FMT], dlo_q, dhi_q);
    period_len = {1'b0, pr_q, 2'b00} + 11'h004;
    over = {1'b0, duty_val} > period_len;
    ctrl_rd = {ctrl_q[CTL_EN], 1'b0, out_q, ctrl_q[CTL_FMT:0]};
    wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  end

  // Next state of registers, timer, output and bus
  always_comb
  begin
    ctrl_d = ctrl_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    pr_d = pr_q;
    tctl_d = tctl_q;
    pctl_d = pctl_q;
    ps_d = ps_q;
    tmr_d = tmr_q;
    dbuf_d = dbuf_q;
    out_d = out_q;
    ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    rdat_d = 32'h0000_0000;
    // Register writes, low byte lane only
    if (wr)
    begin
      case (wb_adr_i)
        ADR_UNIT_CONTROL: ctrl_d = {wb_dat_i[7], 2'b00, wb_dat_i[4:0]};
        ADR_DUTY_LOW: dlo_d = wb_dat_i[7:0];
        ADR_DUTY_HIGH: dhi_d = wb_dat_i[7:0];
        ADR_PERIOD_LIMIT: pr_d = wb_dat_i[7:0];
        ADR_TIMER_CTRL: tctl_d = wb_dat_i[7:0];
        ADR_PERIOD_TIMER: tmr_d = wb_dat_i[7:0];
        ADR_PIN_CTRL: pctl_d = wb_dat_i[7:0];
        default: ;
      endcase
    end
    // Register reads, unmapped reads zero
    if (ack_d & ~wb_we_i)
    begin
      case (wb_adr_i)
        ADR_UNIT_CONTROL: rdat_d = {24'h000000, ctrl_rd};
        ADR_DUTY_LOW: rdat_d = {24'h000000, dlo_q};
        ADR_DUTY_HIGH: rdat_d = {24'h000000, dhi_q};
        ADR_PERIOD_LIMIT: rdat_d = {24'h000000, pr_q};
        ADR_TIMER_CTRL: rdat_d = {24'h000000, tctl_q};
        ADR_PERIOD_TIMER: rdat_d = {24'h000000, tmr_q};
        ADR_PIN_CTRL: rdat_d = {24'h000000, pctl_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    // Prescaler and period timer from the system clock
    if (tctl_q[TCT_ON])
    begin
      ps_d = tick_end ? 8'h00 : ps_q + 8'h01;
    end
    if (roll)
    begin
      tmr_d = 8'h00;
      dbuf_d = duty_val;
    end
    else if (tick_end)
    begin
      tmr_d = tmr_q + 8'h01;
    end
    // Output waveform; the pin falls as the time base reaches the duty
    tb_next = {tmr_d, sub_bits(ps_d, tctl_q[TCT_PS_HI:0])};
    if (!pwm_on)
    begin
      out_d = 1'b0;
    end
    else if (roll)
    begin
      if (over)
      begin
        out_d = out_q;
      end
      else
      begin
        out_d = (duty_val != 10'h000);
      end
    end
    else if (tb_next == dbuf_q)
    begin
      out_d = 1'b0;
    end
  end

  // Pin mapping and drive enables
  always_comb
  begin
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      pin_d[i] = out_d & (pctl_d[PIN_MAP_HI:0] == 2'(i));
      oe_d[i] = ~pctl_d[PIN_DIR] & ctrl_d[CTL_EN]
                & (pctl_d[PIN_MAP_HI:0] == 2'(i));
    end
  end

  // Register all state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= RST_UNIT_CONTROL;
      dlo_q <= RST_DUTY;
      dhi_q <= RST_DUTY;
      pr_q <= RST_PERIOD_LIMIT;
      tctl_q <= RST_TIMER_CTRL;
      pctl_q <= RST_PIN_CTRL;
      ps_q <= 8'h00;
      tmr_q <= 8'h00;
      dbuf_q <= 10'h000;
      out_q <= 1'b0;
      pin_o <= '0;
      pin_oe_o <= '0;
      taps_o <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      pr_q <= pr_d;
      tctl_q <= tctl_d;
      pctl_q <= pctl_d;
      ps_q <= ps_d;
      tmr_q <= tmr_d;
      dbuf_q <= dbuf_d;
      out_q <= out_d;
      pin_o <= pin_d;
      pin_oe_o <= oe_d;
      taps_o <= {5{out_d}};
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_over_hold;
    pwm_on && roll && over |=> out_q == $past(out_q);
  endproperty
  a_over_hold: assert property (p_over_hold)
    else $error("output moved with width over period");

  sequence s_no_step3;
    !tick_end ##1 !tick_end ##1 !tick_end;
  endsequence
  property p_tick_rate;
    tctl_q[TCT_ON] && tctl_q[TCT_PS_HI:0] == 2'h0 && tick_end
      && $stable(tctl_q) |=> s_no_step3;
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("timer step not every four clocks");

  property p_reset;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> ctrl_q == 8'h00 && pin_oe_o == '0 && !out_q;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear unit or release pins");

  property p_taps;
    taps_o == {5{out_q}};
  endproperty
  a_taps: assert property (p_taps)
    else $error("tap differs from waveform");

  property p_out_read;
    ack_d && !wb_we_i && wb_adr_i == ADR_UNIT_CONTROL
      |=> wb_dat_o[CTL_OUT] == $past(out_q);
  endproperty
  a_out_read: assert property (p_out_read)
    else $error("status bit does not show output");

  property p_roll;
    roll && !wr |=> tmr_q == 8'h00 && dbuf_q == $past(duty_val);
  endproperty
  a_roll: assert property (p_roll)
    else $error("period end did not clear timer or latch duty");

  property p_match_clear;
    pwm_on && !roll && tb_next == dbuf_q |=> !out_q;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("duty match did not clear output");

  property p_buffer_hold;
    !roll |=> $stable(dbuf_q);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold)
    else $error("active duty changed mid period");

  property p_mode_off;
    !pwm_on |=> !out_q;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("output high outside pwm mode");

endmodule

`default_nettype wire

// File: src/ccpu_pkg.sv
// Constants, register map and carrier types of the PWM unit.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package ccpu_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] ADR_DUTY_LOW = 8'h04;
  localparam logic [7:0] ADR_DUTY_HIGH = 8'h08;
  localparam logic [7:0] ADR_PERIOD_LIMIT = 8'h0C;
  localparam logic [7:0] ADR_TIMER_CTRL = 8'h10;
  localparam logic [7:0] ADR_PERIOD_TIMER = 8'h14;
  localparam logic [7:0] ADR_PIN_CTRL = 8'h18;

  // Control register fields
  localparam int CTL_EN = 7;
  localparam int CTL_OUT = 5;
  localparam int CTL_FMT = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 2;

  // Timer control fields
  localparam int TCT_ON = 7;
  localparam int TCT_PS_HI = 1;

  // Pin control fields: input direction bit, map select
  localparam int PIN_DIR = 7;
  localparam int PIN_MAP_HI = 1;
  localparam int PIN_COUNT = 4;

  // Reset values
  localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'h00;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
  localparam logic [7:0] RST_PIN_CTRL = 8'h80;

  // Prescaler masks for 1:1/4/16/64, giving 4/16/64/256 system clocks per timer step
  localparam logic [7:0] PS_MASK_1 = 8'h03;
  localparam logic [7:0] PS_MASK_4 = 8'h0F;
  localparam logic [7:0] PS_MASK_16 = 8'h3F;
  localparam logic [7:0] PS_MASK_64 = 8'hFF;

  // Internal copies of the waveform for on-chip consumers
  typedef struct packed {
    logic wave_gen;
    logic adc_trig;
    logic timer_rst;
    logic meas_window;
    logic logic_cell;
  } ccpu_taps_s;

endpackage

// File: testbench/ccpu_load.sv
// Load on the mapped pin plus a watcher of the on-chip taps.
// Assumes a pull-down on the pin, so an undriven pin reads low.
`timescale 1ns/100ps
`default_nettype none

module ccpu_load
  import ccpu_pkg::*;
(
  // Pins of the unit
  input wire logic [3:0] pin_i,
  input wire logic [3:0] pin_oe_i,
  input wire logic [1:0] sel_i,
  input wire ccpu_taps_s taps_i,
  // Observed level and tap agreement
  output logic level_o,
  output logic taps_ok_o
);
  // Wire level, pulled low when not driven
  assign level_o = pin_oe_i[sel_i] ? pin_i[sel_i] : 1'b0;
  // Every consumer sees the same waveform
  assign taps_ok_o = (taps_i === {5{level_o}});
endmodule
`default_nettype wire

// File: testbench/ccpu_unit_test.sv
// Self-checking bench of the PWM unit over classic Wishbone.
// Assumes limit 1 at 1:1 prescale, so one period is 8 clocks.
`timescale 1ns/100ps
`default_nettype none

module ccpu_unit_test import ccpu_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, lvl, tok;
  logic [3:0] pin, oe;
  logic [1:0] map = 2'h0;
  ccpu_taps_s taps;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  ccpu_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_o(pin),
    .pin_oe_o(oe), .taps_o(taps));
  ccpu_load load (.pin_i(pin), .pin_oe_i(oe), .sel_i(map),
    .taps_i(taps), .level_o(lvl), .taps_ok_o(tok));

  // Clock, 40 ns period
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %0h got %0h", nm, e, g);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d,
          output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask

  // Duty pair packed per alignment bit
  task setd(input logic f, input logic [9:0] d);
    if (f)
    begin
      wr(ADR_DUTY_HIGH, d[9:2]);
      wr(ADR_DUTY_LOW, {d[1:0], 6'h00});
    end
    else
    begin
      wr(ADR_DUTY_LOW, d[7:0]);
      wr(ADR_DUTY_HIGH, {6'h00, d[9:8]});
    end
  endtask

  // High clocks over two periods, taps checked each clock
  task meas(input int e, input string nm);
    int c;
    int bad;
    c = 0;
    bad = 0;
    repeat (16) @(posedge clk_i);
    repeat (16)
    begin
      @(posedge clk_i);
      c += (lvl === 1'b1);
      bad += (tok !== 1'b1 || (lvl !== 1'b0 && lvl !== 1'b1));
    end
    chk(nm, e, c);
    chk("taps", 0, bad);
  endtask

  // High clocks over one 32-clock period at 1:4 prescale
  task meas_ps(input int e, input string nm);
    int c;
    c = 0;
    repeat (64) @(posedge clk_i);
    repeat (32)
    begin
      @(posedge clk_i);
      c += (lvl === 1'b1);
    end
    chk(nm, e, c);
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_UNIT_CONTROL, RST_UNIT_CONTROL, "ctl_rst");
    rd(ADR_PIN_CTRL, RST_PIN_CTRL, "pin_rst");
    rd(8'h1C, 8'h00, "unmapped");
    wr(ADR_UNIT_CONTROL, 8'hEC);
    rd(ADR_UNIT_CONTROL, 8'h8C, "ctl_ro");
    wr(ADR_PERIOD_LIMIT, 8'h01);
    wr(ADR_PIN_CTRL, 8'h00);
    wr(ADR_TIMER_CTRL, 8'h80);
    setd(1'b0, 10'd4);
    meas(8, "d4");
    chk("oe", 4'h1, oe);
    setd(1'b0, 10'd2);
    meas(4, "d2");
    setd(1'b0, 10'd8);
    meas(16, "d8");
    rd(ADR_UNIT_CONTROL, 8'hAC, "ctl_out");
    setd(1'b0, 10'd0);
    meas(0, "d0");
    setd(1'b0, 10'd9);
    meas(0, "dbig");
    wr(ADR_UNIT_CONTROL, 8'h9C);
    setd(1'b1, 10'd6);
    meas(12, "fmt1");
    wr(ADR_UNIT_CONTROL, 8'h98);
    meas(0, "mode10");
    wr(ADR_UNIT_CONTROL, 8'h9F);
    meas(12, "mode11");
    wr(ADR_PIN_CTRL, 8'h02);
    map <= 2'h2;
    meas(12, "map2");
    chk("oe2", 4'h4, oe);
    wr(ADR_TIMER_CTRL, 8'h81);
    setd(1'b1, 10'd4);
    meas_ps(16, "ps4");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("oe_rst", 4'h0, oe);
    rst_i <= 1'b0;
    rd(ADR_PIN_CTRL, RST_PIN_CTRL, "pin_rst2");
    rd(ADR_UNIT_CONTROL, RST_UNIT_CONTROL, "ctl_rst2");
    end_sim();
  end
endmodule
`default_nettype wire
